// ==== core/cgc_pkg.sv ====
// Constants and types for the clock generator configuration block
`default_nettype none
package cgc_pkg;
    localparam logic [1:0] ADDR_CTRL_ONE  = 2'h0;
    localparam logic [1:0] ADDR_CTRL_TWO  = 2'h1;
    localparam logic [1:0] ADDR_STATUS    = 2'h2;
    localparam logic [1:0] ADDR_TRIM      = 2'h3;
    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
    localparam logic [7:0] TRIM_RESET     = 8'h80;
    localparam int GAIN_BIT         = 7;
    localparam int RANGE_BIT        = 6;
    localparam int XTAL_SEL_BIT     = 5;
    localparam int SCHEME_LSB       = 3;
    localparam int KEEP_BIT         = 2;
    localparam int CLK_DET_OFF_BIT  = 1;
    localparam int LOCK_IRQ_OFF_BIT = 7;
    localparam int MULT_LSB         = 4;
    localparam int CLK_IRQ_OFF_BIT  = 3;
    localparam int DIV_LSB          = 0;
    // Status layout: lock lost, clock lost, pending, lock, stable
    localparam int ST_LOLS = 4;
    localparam int ST_LOCS = 3;
    localparam int ST_IRQ  = 2;
    localparam int ST_LOCK = 1;
    localparam int ST_STAB = 0;
    localparam int CLOCK_MHZ       = 100;
    localparam int STABLE_TIME_US  = 10;
    localparam int STABLE_CYCLES   = STABLE_TIME_US * CLOCK_MHZ;
    localparam int REF_LOSS_TIME_US = 2;
    localparam int REF_LOSS_CYCLES = REF_LOSS_TIME_US * CLOCK_MHZ;
    localparam logic [6:0] PRESCALE_LOW  = 7'h40;
    localparam logic [6:0] PRESCALE_HIGH = 7'h01;
    localparam logic [2:0] REF_GEN_DIVIDE = 3'h7;
    typedef enum logic [1:0] {
        CGC_SELF_CLOCKED = 2'b00,
        CGC_LOOP_INT     = 2'b01,
        CGC_BYPASS_EXT   = 2'b10,
        CGC_LOOP_EXT     = 2'b11
    } cgc_scheme_e;
    typedef enum logic [1:0] {
        CGC_SETTLE = 2'b00,
        CGC_STABLE = 2'b01,
        CGC_LOST   = 2'b11
    } cgc_state_e;
endpackage
`default_nettype wire

// ==== core/cgc_sync.sv ====
// Two-flop synchroniser for pin-level inputs
`default_nettype none
module cgc_sync (
    input  wire logic clock_i,
    input  wire logic resetn_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_q;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= 1'b0;
            q_o    <= 1'b0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule // cgc_sync

// ==== core/cgc_divider.sv ====
// Reduction divider: one enable pulse every 2**code cycles
`default_nettype none
module cgc_divider (
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    input  wire logic [2:0] code_i,
    output logic            tick_o
);
    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic       tick_d;
    logic [6:0] limit;
    always_comb begin
        limit  = 7'((8'h01 << code_i) - 8'h01);
        tick_d = (cnt_q >= limit);
        cnt_d  = tick_d ? 7'h00 : 7'(cnt_q + 7'h01);
    end
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q  <= 7'h00;
            tick_o <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_o <= tick_d;
        end
    end
endmodule // cgc_divider

// ==== core/cgc_config.sv ====
// Clock generator configuration, mode selection and loss monitoring
//
// Chosen here: strobed register access and the register addresses.
`default_nettype none
module cgc_config (
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    input  wire logic [1:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       ext_ref_clk_i,
    input  wire logic       loop_locked_i,
    output logic      [1:0] scheme_o,
    output logic            loop_engaged_o,
    output logic            use_external_o,
    output logic            crystal_request_o,
    output logic            high_range_o,
    output logic            high_gain_o,
    output logic            osc_keep_on_o,
    output logic      [6:0] prescale_o,
    output logic      [4:0] multiply_o,
    output logic      [7:0] divide_o,
    output logic      [2:0] ref_gen_divide_o,
    output logic      [7:0] trim_o,
    output logic            out_tick_o,
    output logic            bus_tick_o,
    output logic            irq_o
);
    logic [7:0] ctrl1_q, ctrl1_d;
    logic [7:0] ctrl2_q, ctrl2_d;
    logic [7:0] trim_q,  trim_d;
    logic [7:0] rdata_d;
    logic       lols_q, lols_d, locs_q, locs_d, irq_d;
    logic       lock_s, lock_prev_q, ref_s, ref_prev_q;
    logic [9:0] stab_cnt_q, stab_cnt_d;
    logic [7:0] loss_cnt_q, loss_cnt_d;
    logic       ref_lost;
    logic       bus_tog_q, bus_tog_d;
    logic       div_tick;
    cgc_pkg::cgc_state_e state_q, state_d;
    logic [1:0] scheme;
    logic       uses_ext;

    // N from code: 4 + 2*code
    function automatic logic [4:0] mult_of(input logic [2:0] c);
        mult_of = 5'(5'h04 + {1'b0, c, 1'b0});
    endfunction
    function automatic logic [7:0] div_of(input logic [2:0] c);
        div_of = 8'(8'h01 << c);
    endfunction

    cgc_sync u_lock_sync (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .d_i      (loop_locked_i),
        .q_o      (lock_s)
    );
    cgc_sync u_ref_sync (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .d_i      (ext_ref_clk_i),
        .q_o      (ref_s)
    );
    cgc_divider u_rdiv (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .code_i   (ctrl2_q[cgc_pkg::DIV_LSB +: 3]),
        .tick_o   (div_tick)
    );

    always_comb begin
        scheme   = ctrl1_q[cgc_pkg::SCHEME_LSB +: 2];
        uses_ext = scheme[1];
    end

    // Register file
    always_comb begin
        ctrl1_d = ctrl1_q;
        ctrl2_d = ctrl2_q;
        trim_d  = trim_q;
        if (wr_i) begin
            unique case (addr_i)
                cgc_pkg::ADDR_CTRL_ONE: ctrl1_d = {wdata_i[7:1], 1'b0};
                cgc_pkg::ADDR_CTRL_TWO: ctrl2_d = wdata_i;
                cgc_pkg::ADDR_TRIM:     trim_d  = wdata_i;
                cgc_pkg::ADDR_STATUS:   ;
            endcase
        end
        rdata_d = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                cgc_pkg::ADDR_CTRL_ONE: rdata_d = {ctrl1_q[7:1], 1'b0};
                cgc_pkg::ADDR_CTRL_TWO: rdata_d = ctrl2_q;
                cgc_pkg::ADDR_TRIM:     rdata_d = trim_q;
                cgc_pkg::ADDR_STATUS:   rdata_d = {3'h0, lols_q, locs_q, irq_o,
                                                   lock_s, state_q == cgc_pkg::CGC_STABLE};
            endcase
        end
    end
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl1_q <= cgc_pkg::CTRL_ONE_RESET;
            ctrl2_q <= cgc_pkg::CTRL_TWO_RESET;
            trim_q  <= cgc_pkg::TRIM_RESET;
            rdata_o <= 8'h00;
        end else begin
            ctrl1_q <= ctrl1_d;
            ctrl2_q <= ctrl2_d;
            trim_q  <= trim_d;
            rdata_o <= rdata_d;
        end
    end

    // Stability tracking: any scheme or range change restarts settling
    always_comb begin
        state_d    = state_q;
        stab_cnt_d = stab_cnt_q;
        if (ctrl1_d[6:3] != ctrl1_q[6:3]) begin
            state_d    = cgc_pkg::CGC_SETTLE;
            stab_cnt_d = 10'h000;
        end else begin
            unique case (state_q)
                cgc_pkg::CGC_SETTLE: begin
                    if (ref_lost) begin
                        state_d = cgc_pkg::CGC_LOST;
                    end else if (stab_cnt_q == 10'(cgc_pkg::STABLE_CYCLES - 1)) begin
                        state_d = cgc_pkg::CGC_STABLE;
                    end else begin
                        stab_cnt_d = 10'(stab_cnt_q + 10'h001);
                    end
                end
                cgc_pkg::CGC_STABLE: begin
                    if (ref_lost) begin
                        state_d = cgc_pkg::CGC_LOST;
                    end
                end
                cgc_pkg::CGC_LOST: begin
                    if (!ref_lost) begin
                        state_d    = cgc_pkg::CGC_SETTLE;
                        stab_cnt_d = 10'h000;
                    end
                end
                default: state_d = cgc_pkg::CGC_SETTLE;
            endcase
        end
    end

    // Reference activity watchdog, only meaningful on external schemes
    always_comb begin
        if (!uses_ext || (ref_s != ref_prev_q)) begin
            loss_cnt_d = 8'h00;
        end else if (loss_cnt_q != 8'(cgc_pkg::REF_LOSS_CYCLES)) begin
            loss_cnt_d = 8'(loss_cnt_q + 8'h01);
        end else begin
            loss_cnt_d = loss_cnt_q;
        end
        // Detection is active while the disable bit is clear
        ref_lost = !ctrl1_q[cgc_pkg::CLK_DET_OFF_BIT] &&
                   (loss_cnt_q == 8'(cgc_pkg::REF_LOSS_CYCLES));
    end

    // Sticky loss flags; a new event wins over a software clear
    always_comb begin
        lols_d = lols_q;
        locs_d = locs_q;
        if (wr_i && addr_i == cgc_pkg::ADDR_STATUS) begin
            lols_d = 1'b0;
            locs_d = 1'b0;
        end
        if (scheme[0] && lock_prev_q && !lock_s) begin
            lols_d = 1'b1;
        end
        if (ref_lost) begin
            locs_d = 1'b1;
        end
        irq_d = (lols_d && !ctrl2_q[cgc_pkg::LOCK_IRQ_OFF_BIT]) ||
                (locs_d && !ctrl2_q[cgc_pkg::CLK_IRQ_OFF_BIT]);
        bus_tog_d = div_tick ? !bus_tog_q : bus_tog_q;
    end
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q     <= cgc_pkg::CGC_SETTLE;
            stab_cnt_q  <= 10'h000;
            loss_cnt_q  <= 8'h00;
            lols_q      <= 1'b0;
            locs_q      <= 1'b0;
            irq_o       <= 1'b0;
            lock_prev_q <= 1'b0;
            ref_prev_q  <= 1'b0;
            bus_tog_q   <= 1'b0;
        end else begin
            state_q     <= state_d;
            stab_cnt_q  <= stab_cnt_d;
            loss_cnt_q  <= loss_cnt_d;
            lols_q      <= lols_d;
            locs_q      <= locs_d;
            irq_o       <= irq_d;
            lock_prev_q <= lock_s;
            ref_prev_q  <= ref_s;
            bus_tog_q   <= bus_tog_d;
        end
    end

    // Frequency plan outputs to the analog loop
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scheme_o          <= cgc_pkg::CGC_SELF_CLOCKED;
            loop_engaged_o    <= 1'b0;
            use_external_o    <= 1'b0;
            crystal_request_o <= 1'b0;
            high_range_o      <= 1'b0;
            high_gain_o       <= 1'b0;
            osc_keep_on_o     <= 1'b0;
            prescale_o        <= cgc_pkg::PRESCALE_LOW;
            multiply_o        <= 5'h04;
            divide_o          <= 8'h01;
            ref_gen_divide_o  <= cgc_pkg::REF_GEN_DIVIDE;
            trim_o            <= cgc_pkg::TRIM_RESET;
            out_tick_o        <= 1'b0;
            bus_tick_o        <= 1'b0;
        end else begin
            scheme_o          <= scheme;
            loop_engaged_o    <= scheme[0];
            use_external_o    <= uses_ext;
            crystal_request_o <= uses_ext && ctrl1_q[cgc_pkg::XTAL_SEL_BIT];
            high_range_o      <= ctrl1_q[cgc_pkg::RANGE_BIT];
            high_gain_o       <= ctrl1_q[cgc_pkg::GAIN_BIT];
            osc_keep_on_o     <= ctrl1_q[cgc_pkg::KEEP_BIT];
            // Internal path always uses 64; external follows range
            prescale_o        <= (uses_ext && ctrl1_q[cgc_pkg::RANGE_BIT])
                                 ? cgc_pkg::PRESCALE_HIGH
                                 : cgc_pkg::PRESCALE_LOW;
            multiply_o        <= mult_of(ctrl2_q[cgc_pkg::MULT_LSB +: 3]);
            divide_o          <= div_of(ctrl2_q[cgc_pkg::DIV_LSB +: 3]);
            ref_gen_divide_o  <= cgc_pkg::REF_GEN_DIVIDE;
            trim_o            <= trim_q;
            out_tick_o        <= div_tick;
            bus_tick_o        <= div_tick && bus_tog_q;
        end
    end
endmodule // cgc_config
`default_nettype wire

// ==== testbench/cgc_config_chk.sv ====
// Port assertions for the clock generator configuration block
`default_nettype none
module cgc_config_chk (
    input wire logic       clock_i,
    input wire logic       resetn_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [1:0] scheme_o,
    input wire logic       use_external_o,
    input wire logic       crystal_request_o,
    input wire logic       high_range_o,
    input wire logic [6:0] prescale_o,
    input wire logic [4:0] multiply_o,
    input wire logic [7:0] divide_o,
    input wire logic [2:0] ref_gen_divide_o,
    input wire logic       irq_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [10:0] w1_q;
    logic [10:0] w2_q;
    // Writes show at the outputs two edges later
    always_ff @(posedge clock_i) begin
        w1_q <= {wr_i, addr_i, wdata_i};
        w2_q <= w1_q;
    end
    wire logic to_one = w2_q[10] && (w2_q[9:8] == cgc_pkg::ADDR_CTRL_ONE);
    wire logic to_two = w2_q[10] && (w2_q[9:8] == cgc_pkg::ADDR_CTRL_TWO);
    wire logic to_st  = w2_q[10] && (w2_q[9:8] == cgc_pkg::ADDR_STATUS);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    property p_bit0;
        $past(rd_i) && $past(addr_i) == cgc_pkg::ADDR_CTRL_ONE |-> !rdata_o[0];
    endproperty
    a_bit0: assert property (p_bit0) else $error("ctrl one bit 0 set");
    property p_mult;
        to_two |-> multiply_o == 5'h04 + {1'b0, w2_q[6:4], 1'b0};
    endproperty
    a_mult: assert property (p_mult) else $error("bad multiplier");
    property p_div;
        to_two |-> divide_o == 8'h01 << w2_q[2:0];
    endproperty
    a_div: assert property (p_div) else $error("bad divisor");
    property p_scheme;
        to_one |-> scheme_o == w2_q[4:3];
    endproperty
    a_scheme: assert property (p_scheme) else $error("bad scheme");
    property p_pre;
        prescale_o == ((use_external_o && high_range_o) ? 7'h01 : 7'h40);
    endproperty
    a_pre: assert property (p_pre) else $error("bad prescale");
    property p_xtal;
        crystal_request_o |-> use_external_o;
    endproperty
    a_xtal: assert property (p_xtal) else $error("crystal on internal");
    property p_irg;
        ref_gen_divide_o == 3'h7;
    endproperty
    a_irg: assert property (p_irg) else $error("bad reference divide");
    property p_clear;
        to_st |-> !irq_o;
    endproperty
    a_clear: assert property (p_clear) else $error("irq after clear");
endmodule // cgc_config_chk
bind cgc_config cgc_config_chk u_chk (
    .clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scheme_o(scheme_o),
    .use_external_o(use_external_o), .crystal_request_o(crystal_request_o),
    .high_range_o(high_range_o), .prescale_o(prescale_o), .multiply_o(multiply_o),
    .divide_o(divide_o), .ref_gen_divide_o(ref_gen_divide_o), .irq_o(irq_o)
);
`default_nettype wire

// ==== testbench/cgc_ref_src.sv ====
// Behavioural external crystal or reference clock source
`default_nettype none
module cgc_ref_src #(
    parameter int HALF_NS = 37
) (
    input  wire logic run_i,
    output logic      ref_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        ref_o = 1'b0;
        forever begin
            #(HALF_NS);
            // A stopped crystal freezes its level
            if (run_i) begin
                ref_o = ~ref_o;
            end
        end
    end
endmodule // cgc_ref_src
`default_nettype wire

// ==== testbench/cgc_config_tb_top.sv ====
// Self-checking bench for the clock generator configuration block
`default_nettype none
`define CGC_CHECK(nm, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module cgc_config_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clock_i, resetn_i, wr_i, rd_i, loop_locked_i, ref_run, ext_ref;
    logic       engaged, xtal, high_gain, out_tick, bus_tick, irq;
    logic [1:0] addr_i, scheme;
    logic [7:0] wdata_i, rdata, divide, trim;
    logic [6:0] prescale;
    logic [4:0] multiply;
    int         failures = 0;
    int         comparisons = 0;
    int         n_out, n_bus;
    cgc_config dut (
        .clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .ext_ref_clk_i(ext_ref),
        .loop_locked_i(loop_locked_i), .scheme_o(scheme), .loop_engaged_o(engaged),
        .use_external_o(), .crystal_request_o(xtal), .high_range_o(),
        .high_gain_o(high_gain), .osc_keep_on_o(), .prescale_o(prescale),
        .multiply_o(multiply), .divide_o(divide), .ref_gen_divide_o(), .trim_o(trim),
        .out_tick_o(out_tick), .bus_tick_o(bus_tick), .irq_o(irq)
    );
    cgc_ref_src xo (.run_i(ref_run), .ref_o(ext_ref));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic end_sim();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Returns once the outputs carry the new value
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
        repeat (3) @(posedge clock_i);
    endtask
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e,
                          input string nm);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        @(negedge clock_i);
        `CGC_CHECK(nm, e, rdata & m)
        @(posedge clock_i);
    endtask
    task automatic mode_chk(input logic [7:0] v, input logic [6:0] p, input logic x);
        reg_wr(cgc_pkg::ADDR_CTRL_ONE, v);
        `CGC_CHECK("scheme", v[4:3], scheme)
        `CGC_CHECK("engaged", v[3], engaged)
        `CGC_CHECK("prescale", p, prescale)
        `CGC_CHECK("crystal", x, xtal)
        `CGC_CHECK("high_gain", v[7], high_gain)
        rd_chk(cgc_pkg::ADDR_CTRL_ONE, 8'hff, v & 8'hfe, "ctrl_one");
    endtask
    // Clock loss stops the crystal; lock loss raises then drops the lock
    task automatic loss_chk(input logic [7:0] c2, input logic clk, input logic [7:0] m,
                            input logic [7:0] f, input logic e_irq);
        reg_wr(cgc_pkg::ADDR_CTRL_TWO, c2);
        ref_run       <= !clk;
        loop_locked_i <= !clk;
        repeat (300) @(posedge clock_i);
        loop_locked_i <= 1'b0;
        repeat (10) @(posedge clock_i);
        rd_chk(cgc_pkg::ADDR_STATUS, m, f, "flag");
        `CGC_CHECK("irq", e_irq, irq)
        ref_run <= 1'b1;
        repeat (10) @(posedge clock_i);
        reg_wr(cgc_pkg::ADDR_STATUS, 8'h00);
        `CGC_CHECK("irq_clear", 1'b0, irq)
        rd_chk(cgc_pkg::ADDR_STATUS, 8'h18, 8'h00, "flag_clear");
    endtask
    initial begin
        repeat (20000) @(posedge clock_i);
        failures++;
        $display("watchdog expired");
        end_sim();
    end
    initial begin
        {addr_i, wdata_i, wr_i, rd_i, loop_locked_i} = '0;
        ref_run  = 1'b1;
        resetn_i = 1'b0;
        repeat (16) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        `CGC_CHECK("scheme", 2'b00, scheme)
        `CGC_CHECK("mult", 5'h04, multiply)
        `CGC_CHECK("div", 8'h01, divide)
        rd_chk(cgc_pkg::ADDR_CTRL_ONE, 8'hff, 8'h00, "ctrl_one");
        rd_chk(cgc_pkg::ADDR_TRIM, 8'hff, cgc_pkg::TRIM_RESET, "trim");
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            reg_wr(cgc_pkg::ADDR_CTRL_TWO, {1'b0, c[2:0], 1'b0, c[2:0]});
            `CGC_CHECK("mult", 5'(4 + 2 * c), multiply)
            `CGC_CHECK("div", 8'(1 << c), divide)
        end
        $display("test codes done");
        mode_chk(8'h91, 7'h40, 1'b0);
        mode_chk(8'h28, 7'h40, 1'b0);
        mode_chk(8'h79, 7'h01, 1'b1);
        rd_chk(cgc_pkg::ADDR_STATUS, 8'h01, 8'h00, "stable");
        repeat (1100) @(posedge clock_i);
        rd_chk(cgc_pkg::ADDR_STATUS, 8'h01, 8'h01, "stable");
        $display("test modes done");
        loss_chk(8'h30, 1'b1, 8'h09, 8'h08, 1'b1);
        loss_chk(8'h38, 1'b1, 8'h08, 8'h08, 1'b0);
        reg_wr(cgc_pkg::ADDR_CTRL_ONE, 8'h7a);
        loss_chk(8'h30, 1'b1, 8'h08, 8'h00, 1'b0);
        reg_wr(cgc_pkg::ADDR_CTRL_ONE, 8'h28);
        loss_chk(8'h31, 1'b0, 8'h10, 8'h10, 1'b1);
        loss_chk(8'hb1, 1'b0, 8'h10, 8'h10, 1'b0);
        $display("test losses done");
        reg_wr(cgc_pkg::ADDR_CTRL_TWO, 8'h32);
        reg_wr(cgc_pkg::ADDR_TRIM, 8'h5a);
        `CGC_CHECK("trim", 8'h5a, trim)
        rd_chk(cgc_pkg::ADDR_TRIM, 8'hff, 8'h5a, "trim");
        reg_wr(cgc_pkg::ADDR_CTRL_TWO, 8'h31);
        n_out = 0;
        n_bus = 0;
        repeat (64) begin
            @(negedge clock_i);
            n_out += int'(out_tick);
            n_bus += int'(bus_tick);
        end
        `CGC_CHECK("out_ticks", 32, n_out)
        `CGC_CHECK("bus_ticks", 16, n_bus)
        @(posedge clock_i);
        $display("test trim and ticks done");
        end_sim();
    end
endmodule // cgc_config_tb_top
`default_nettype wire
